// [core/link_event_pkg.sv]
// Constants shared by the link event flag block: register offsets, field positions,
// reset values and timing figures.
// Assumes a 32-bit classic Wishbone register bus and a 50 MHz controller clock.
package link_event_pkg;
    localparam int WB_ADDR_W = 8;

    // Byte addresses of the register words
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0C;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    localparam logic [7:0] ADDR_FIFO_CTRL = 8'h1C;
    localparam logic [7:0] ADDR_DIAG = 8'h20;

    // Event flag positions in link_event_flags
    localparam int BIT_SUMMARY = 0;
    localparam int BIT_PHY_REG = 2;
    localparam int BIT_PHY_RESET = 3;
    localparam int BIT_SELF_ID_DONE = 4;
    localparam int BIT_TX_READY = 5;
    localparam int BIT_RX_BLOCK = 6;
    localparam int BIT_CMD_RESET = 7;
    localparam int BIT_ACK_EVENT = 8;
    localparam int BIT_ISO_TX_ERR = 11;
    localparam int BIT_ASYNC_TX_ERR = 12;
    localparam int BIT_BUSY_ACK = 14;
    localparam int BIT_HDR_CRC = 15;
    localparam int BIT_TCODE_ERR = 16;
    localparam int BIT_CYCLE_OVERRUN = 19;

    // Bits that hold a flag; all others of the word except summary bit 0 read as zero
    localparam logic [31:0] FLAG_IMPL_MASK = 32'h0009_D9FC;
    localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;

    // Control, mask, fifo-control and diagnostic bit positions
    localparam int CTRL_KEEP_SID_BIT = 1;
    localparam int MASK_MASTER_BIT = 0;
    localparam int FIFO_CLR_ASYNC_BIT = 0;
    localparam int DIAG_WE_BIT = 0;

    // Isochronous cycle length limit
    localparam int CLOCK_MHZ = 50;
    localparam int CYCLE_TIME_US = 125;
    localparam int CYCLE_LIMIT_CYCLES = CYCLE_TIME_US * CLOCK_MHZ;
endpackage

// [core/sticky_flag.sv]
// One sticky event flag: set by hardware, cleared or loaded by software.
// Assumes set, clear and load are single-cycle qualifiers in the i_clock domain.
`timescale 1ns/1ns
module sticky_flag #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_set,
    input wire logic i_clear,
    input wire logic i_load,
    input wire logic i_load_value,
    output logic o_flag
);
    typedef struct packed {
        logic flag;
    } cell_state_t;

    cell_state_t state_reg;
    cell_state_t state_next;

    // Hardware set wins over any software clear or load in the same cycle
    always_comb begin
        state_next = state_reg;
        if (i_set) begin
            state_next.flag = 1'b1;
        end else if (i_load) begin
            state_next.flag = i_load_value;
        end else if (i_clear) begin
            state_next.flag = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '{flag: RESET_VALUE};
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_flag = state_reg.flag;

    a_set_wins: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_set |=> o_flag) else $error("flag not set after set request");
endmodule

// [core/serial_bus_link_event_flags.sv]
// Event flag section of a serial-bus link controller, with its mask, control bits and
// the interrupt output, reached as a classic Wishbone slave.
// Assumes all event inputs are one-cycle pulses or levels synchronous to i_clock.
//
// Behaviour
// - Flag bit 2 when a phy register value lands in the access register.
// - Flag bit 3 when a bus reset begins.
// - Flag bit 4 when the whole bus reset including self-ID is finished.
// - Control bit 1 tells the receiver to keep self-ID packets in the fifo.
// - Flag bit 5 when the transmitter is idle and ready.
// - Unacknowledged non-broadcast async packet means lost arbitration; retry when bus idle.
// - Flag bit 6 when a block or packet enters the general receive fifo.
// - During self-ID reception, bit 6 waits until the bus reset ends.
// - Flag bit 7 on a quadlet write to the reset-start register.
// - Flag bit 8 on acknowledge or timeout after an async packet.
// - Flag bit 11 on invalid iso transmit fifo content.
// - Flag bit 12 when a first quadlet missed the first-entry addresses.
// - Async transmit fifo underflow also raises bit 12.
// - Format error state blocks async sending until software clears the fifo.
// - Isochronous transmission carries on during the format error state.
// - Receive fifo overflow sets bit 14 and answers busy to our packet.
// - Header CRC failure sets bit 15 and the packet is discarded.
// - Flag bit 16 on an invalid transaction code from a transmit fifo.
// - Flag bit 19 when an isochronous cycle lasts over 125 microseconds.
// - Masked flags form the summary; interrupt needs summary and master mask.
// - Read/write mask register at its own address, reset to zero.
// - Diag enable off: writes clear flags; on: every flag bit writable.
`timescale 1ns/1ns
module serial_bus_link_event_flags #(
    parameter int CYCLE_LIMIT = link_event_pkg::CYCLE_LIMIT_CYCLES,
    parameter int CNT_W = 16
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [link_event_pkg::WB_ADDR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    // Events from the link logic
    input wire logic i_phy_reg_value_received,
    input wire logic i_phy_reset_started,
    input wire logic i_self_ident_complete,
    input wire logic i_self_ident_receiving,
    input wire logic i_transmitter_ready,
    input wire logic i_async_nonbcast_sent,
    input wire logic i_acknowledge_valid,
    input wire logic i_bus_idle,
    input wire logic i_receive_block_accepted,
    input wire logic i_command_reset_received,
    input wire logic i_ack_or_timeout_event,
    input wire logic i_iso_tx_format_error,
    input wire logic i_async_first_entry_missed,
    input wire logic i_async_fifo_underflow,
    input wire logic i_general_receive_fifo_overflow,
    input wire logic i_packet_for_node,
    input wire logic i_header_crc_error,
    input wire logic i_transaction_code_error,
    input wire logic i_iso_cycle_start,
    input wire logic i_iso_cycle_end,
    // Controls back to the link logic
    output logic o_keep_self_ident_packets,
    output logic o_async_tx_enable,
    output logic o_iso_tx_enable,
    output logic o_async_fifo_clear,
    output logic o_rearbitrate,
    output logic o_busy_ack_send,
    output logic o_discard_packet,
    output logic o_interrupt
);
    import link_event_pkg::*;

    typedef struct packed {
        logic [31:0] mask;
        logic keep_sid;
        logic diag_we;
        logic async_err;
        logic rx_held;
        logic async_wait;
        logic arb_lost;
        logic retry;
        logic busy_ack;
        logic discard;
        logic fifo_clear;
        logic cyc_active;
        logic cyc_flagged;
        logic [CNT_W-1:0] cyc_cnt;
        logic ack;
        logic [31:0] rdata;
        logic irq;
    } state_t;

    localparam logic [CNT_W-1:0] CYC_LIMIT = CNT_W'(CYCLE_LIMIT);

    state_t state_reg;
    state_t state_next;

    logic [31:0] flags;
    logic [31:0] flag_set;
    logic [31:0] flag_clear;
    logic [31:0] byte_mask;
    logic [31:0] read_word;
    logic flag_load;
    logic summary;
    logic req;
    logic wr_commit;
    logic rx_block_set;
    logic cyc_over;

    assign req = i_wb_cyc & i_wb_stb;
    // A write takes effect at the edge where the master sees ack
    assign wr_commit = req & i_wb_we & state_reg.ack;
    assign byte_mask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

    // Self-ID blocks are reported only once the bus reset completes
    assign rx_block_set = (i_receive_block_accepted & ~i_self_ident_receiving)
                          | (i_self_ident_complete & (state_reg.rx_held | i_receive_block_accepted));

    assign cyc_over = state_reg.cyc_active & ~state_reg.cyc_flagged & (state_reg.cyc_cnt >= CYC_LIMIT);

    always_comb begin
        flag_set = '0;
        flag_set[BIT_PHY_REG] = i_phy_reg_value_received;
        flag_set[BIT_PHY_RESET] = i_phy_reset_started;
        flag_set[BIT_SELF_ID_DONE] = i_self_ident_complete;
        flag_set[BIT_TX_READY] = i_transmitter_ready;
        flag_set[BIT_RX_BLOCK] = rx_block_set;
        flag_set[BIT_CMD_RESET] = i_command_reset_received;
        flag_set[BIT_ACK_EVENT] = i_ack_or_timeout_event;
        flag_set[BIT_ISO_TX_ERR] = i_iso_tx_format_error;
        flag_set[BIT_ASYNC_TX_ERR] = i_async_first_entry_missed | i_async_fifo_underflow;
        flag_set[BIT_BUSY_ACK] = i_general_receive_fifo_overflow;
        flag_set[BIT_HDR_CRC] = i_header_crc_error;
        flag_set[BIT_TCODE_ERR] = i_transaction_code_error;
        flag_set[BIT_CYCLE_OVERRUN] = cyc_over;
    end

    // Plain writes clear the ones written; diagnostic writes load the word
    assign flag_load = wr_commit & (i_wb_adr == ADDR_FLAGS) & state_reg.diag_we;
    assign flag_clear = (wr_commit & (i_wb_adr == ADDR_FLAGS) & ~state_reg.diag_we)
                        ? (i_wb_dat & byte_mask) : '0;

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_flag
            if (FLAG_IMPL_MASK[gi]) begin : g_cell
                sticky_flag #(
                    .RESET_VALUE(FLAGS_RESET[gi])
                ) sticky_flag_inst (
                    .i_clock(i_clock),
                    .i_rst_n(i_rst_n),
                    .i_set(flag_set[gi]),
                    .i_clear(flag_clear[gi]),
                    .i_load(flag_load & byte_mask[gi]),
                    .i_load_value(i_wb_dat[gi]),
                    .o_flag(flags[gi])
                );
            end else begin : g_zero
                assign flags[gi] = 1'b0;
            end
        end
    endgenerate

    assign summary = |(flags & state_reg.mask & FLAG_IMPL_MASK);

    always_comb begin
        read_word = '0;
        unique case (i_wb_adr)
            ADDR_CONTROL: read_word[CTRL_KEEP_SID_BIT] = state_reg.keep_sid;
            ADDR_FLAGS: read_word = {flags[31:1], summary};
            ADDR_MASK: read_word = state_reg.mask;
            ADDR_DIAG: read_word[DIAG_WE_BIT] = state_reg.diag_we;
            default: read_word = '0;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        state_next.retry = 1'b0;
        state_next.busy_ack = 1'b0;
        state_next.discard = 1'b0;
        state_next.fifo_clear = 1'b0;

        // Bus slave: ack one cycle after the request, dropped the cycle after
        state_next.ack = req & ~state_reg.ack;
        if (req & ~state_reg.ack & ~i_wb_we) begin
            state_next.rdata = read_word;
        end

        if (wr_commit) begin
            unique case (i_wb_adr)
                ADDR_CONTROL: begin
                    if (i_wb_sel[0]) begin
                        state_next.keep_sid = i_wb_dat[CTRL_KEEP_SID_BIT];
                    end
                end
                ADDR_MASK: begin
                    state_next.mask = (state_reg.mask & ~byte_mask) | (i_wb_dat & byte_mask);
                end
                ADDR_FIFO_CTRL: begin
                    state_next.fifo_clear = i_wb_sel[0] & i_wb_dat[FIFO_CLR_ASYNC_BIT];
                end
                ADDR_DIAG: begin
                    if (i_wb_sel[0]) begin
                        state_next.diag_we = i_wb_dat[DIAG_WE_BIT];
                    end
                end
                default: begin
                end
            endcase
        end

        // Format error state: leaving it needs a fifo clear, a new error wins
        if (flag_set[BIT_ASYNC_TX_ERR]) begin
            state_next.async_err = 1'b1;
        end else if (state_reg.fifo_clear) begin
            state_next.async_err = 1'b0;
        end

        // Holding self-ID data reports until the reset process ends
        if (i_self_ident_complete) begin
            state_next.rx_held = 1'b0;
        end else if (i_receive_block_accepted & i_self_ident_receiving) begin
            state_next.rx_held = 1'b1;
        end

        // Missing acknowledge after a non-broadcast async packet; a new loss in the retry cycle still retries and is kept pending
        if (state_reg.arb_lost & i_transmitter_ready & i_bus_idle) begin
            state_next.arb_lost = 1'b0;
            state_next.retry = 1'b1;
        end
        if (i_async_nonbcast_sent) begin
            state_next.async_wait = 1'b1;
        end else if (state_reg.async_wait & i_ack_or_timeout_event) begin
            state_next.async_wait = 1'b0;
            state_next.arb_lost = ~i_acknowledge_valid;
        end

        state_next.busy_ack = i_general_receive_fifo_overflow & i_packet_for_node;
        state_next.discard = i_header_crc_error;

        // Isochronous cycle length watch
        if (i_iso_cycle_start) begin
            state_next.cyc_active = 1'b1;
            state_next.cyc_flagged = 1'b0;
            state_next.cyc_cnt = '0;
        end else if (i_iso_cycle_end) begin
            state_next.cyc_active = 1'b0;
        end else if (state_reg.cyc_active) begin
            if (cyc_over) begin
                state_next.cyc_flagged = 1'b1;
            end
            if (state_reg.cyc_cnt != '1) begin
                state_next.cyc_cnt = state_reg.cyc_cnt + 1'b1;
            end
        end

        state_next.irq = summary & state_reg.mask[MASK_MASTER_BIT];
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '0;
            state_reg.mask <= MASK_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_wb_ack = state_reg.ack;
    assign o_wb_dat = state_reg.rdata;
    assign o_keep_self_ident_packets = state_reg.keep_sid;
    assign o_async_tx_enable = ~state_reg.async_err;
    assign o_iso_tx_enable = 1'b1;
    assign o_async_fifo_clear = state_reg.fifo_clear;
    assign o_rearbitrate = state_reg.retry;
    assign o_busy_ack_send = state_reg.busy_ack;
    assign o_discard_packet = state_reg.discard;
    assign o_interrupt = state_reg.irq;

    a_phy_reg_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_phy_reg_value_received |=> flags[BIT_PHY_REG]) else $error("phy register flag missing");
    a_reset_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_phy_reset_started |=> flags[BIT_PHY_RESET]) else $error("bus reset flag missing");
    a_sid_done_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_self_ident_complete |=> flags[BIT_SELF_ID_DONE]
        && (flags[BIT_RX_BLOCK] || !$past(state_reg.rx_held || i_receive_block_accepted)))
        else $error("self-ID end flags");
    a_keep_sid_ctl: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        wr_commit && i_wb_adr == ADDR_CONTROL && i_wb_sel[0]
        |=> o_keep_self_ident_packets == $past(i_wb_dat[CTRL_KEEP_SID_BIT])) else $error("keep self-ID bit");
    a_tx_ready_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_transmitter_ready |=> flags[BIT_TX_READY]) else $error("transmitter ready flag missing");
    a_arb_retry: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_rearbitrate |-> $past(state_reg.arb_lost && i_bus_idle && i_transmitter_ready))
        else $error("retry without lost arbitration");
    a_rx_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_receive_block_accepted && !i_self_ident_receiving |=> flags[BIT_RX_BLOCK])
        else $error("receive data flag missing");
    a_rx_held: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !flags[BIT_RX_BLOCK] && i_receive_block_accepted && i_self_ident_receiving && !i_self_ident_complete
        && !flag_load |=> !flags[BIT_RX_BLOCK]) else $error("receive flag during self-ID");
    a_cmd_reset_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_command_reset_received |=> flags[BIT_CMD_RESET]) else $error("command reset flag missing");
    a_ack_event_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_ack_or_timeout_event |=> flags[BIT_ACK_EVENT]) else $error("acknowledge flag missing");
    a_iso_err_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_iso_tx_format_error |=> flags[BIT_ISO_TX_ERR]) else $error("iso format error flag missing");
    a_async_block: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_async_first_entry_missed || i_async_fifo_underflow)
        |=> !o_async_tx_enable ##1 (!o_async_tx_enable || $past(o_async_fifo_clear)))
        else $error("async sending not blocked");
    a_async_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !o_async_tx_enable && !o_async_fifo_clear |=> !o_async_tx_enable)
        else $error("async sending resumed without fifo clear");
    a_busy_ack: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_general_receive_fifo_overflow && i_packet_for_node |=> o_busy_ack_send && flags[BIT_BUSY_ACK])
        else $error("busy acknowledge missing");
    a_hdr_discard: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_header_crc_error |=> o_discard_packet && flags[BIT_HDR_CRC]) else $error("header error handling");
    a_tcode_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_transaction_code_error |=> flags[BIT_TCODE_ERR]) else $error("transaction code flag missing");
    a_overrun_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        state_reg.cyc_active && !i_iso_cycle_start && !i_iso_cycle_end && state_reg.cyc_cnt == CYC_LIMIT
        |=> flags[BIT_CYCLE_OVERRUN]) else $error("cycle overrun flag missing");
    a_irq_gate: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        ##1 o_interrupt == $past(summary && state_reg.mask[MASK_MASTER_BIT])) else $error("interrupt gating");
    a_mask_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        wr_commit && i_wb_adr == ADDR_MASK && i_wb_sel == 4'hF |=> state_reg.mask == $past(i_wb_dat))
        else $error("mask register write lost");
    a_flag_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        flag_clear[BIT_ACK_EVENT] && !i_ack_or_timeout_event |=> !flags[BIT_ACK_EVENT])
        else $error("flag not cleared by write");
    a_reserved_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        req && !i_wb_we && !state_reg.ack && i_wb_adr == ADDR_FLAGS
        |=> (o_wb_dat & ~FLAG_IMPL_MASK & 32'hFFFF_FFFE) == '0) else $error("reserved flag bits not zero");

    c_retry: cover property (@(posedge i_clock) disable iff (!i_rst_n) o_rearbitrate);
    c_overrun: cover property (@(posedge i_clock) disable iff (!i_rst_n) $rose(flags[BIT_CYCLE_OVERRUN]));
    c_irq: cover property (@(posedge i_clock) disable iff (!i_rst_n) $rose(o_interrupt));
    c_err_leave: cover property (@(posedge i_clock) disable iff (!i_rst_n) $rose(o_async_tx_enable));
endmodule

// [verif/wb_host_model.sv]
// Host processor model: a classic Wishbone master doing single cycles on request.
// Assumes the slave answers with a registered one-cycle ack.
`timescale 1ns/1ns
module wb_host_model (
    input wire logic i_clock,
    input wire logic i_wb_ack,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_cyc,
    output logic o_wb_stb,
    output logic o_wb_we,
    output logic [7:0] o_wb_adr,
    output logic [3:0] o_wb_sel,
    output logic [31:0] o_wb_dat
);
    logic [31:0] last_rdata = 32'h0000_0000;
    initial begin
        o_wb_cyc = 1'b0;
        o_wb_stb = 1'b0;
        o_wb_we = 1'b0;
        o_wb_adr = 8'h00;
        o_wb_sel = 4'h0;
        o_wb_dat = 32'h0000_0000;
    end
    // Holds the request until ack, then drops it and scrambles the released lines
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge i_clock);
        o_wb_cyc <= 1'b1;
        o_wb_stb <= 1'b1;
        o_wb_we <= we;
        o_wb_adr <= adr;
        o_wb_sel <= 4'hF;
        o_wb_dat <= dat;
        do @(posedge i_clock); while (i_wb_ack !== 1'b1);
        last_rdata = i_wb_dat;
        o_wb_cyc <= 1'b0;
        o_wb_stb <= 1'b0;
        o_wb_we <= 1'b0;
        o_wb_adr <= ~adr;
        o_wb_dat <= ~dat;
    endtask
endmodule

// [verif/serial_bus_link_event_flags_tb.sv]
// Self-checking bench for the link event flag block.
// Assumes the Wishbone host model; the cycle limit is shortened to 20 clocks.
`timescale 1ns/1ns
module serial_bus_link_event_flags_tb;
    import link_event_pkg::*;
    localparam int LIM = 20;
    localparam int EB[13] = '{2, 3, 4, 5, 6, 7, 8, 11, 12, 12, 14, 15, 16};
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic [15:0] ev = 16'h0000;
    logic sid_recv = 1'b0;
    logic acknowledge_valid = 1'b0;
    logic idle = 1'b0;
    logic for_node = 1'b1;
    logic wb_cyc, wb_stb, wb_we, o_wb_ack, keep_sid, async_en, iso_en, fifo_clr, rearb, busy, discard, irq;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat, o_wb_dat, mval;
    logic [31:0] exp_q[$];
    int err_total = 0;
    int checks = 0;
    int rearb_n = 0;
    always #10 i_clock = ~i_clock;
    serial_bus_link_event_flags #(.CYCLE_LIMIT(LIM)) serial_bus_link_event_flags_inst (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
        .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_dat), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
        .i_phy_reg_value_received(ev[0]), .i_phy_reset_started(ev[1]), .i_self_ident_complete(ev[2]),
        .i_self_ident_receiving(sid_recv), .i_transmitter_ready(ev[3]), .i_async_nonbcast_sent(ev[13]),
        .i_acknowledge_valid(acknowledge_valid), .i_bus_idle(idle), .i_receive_block_accepted(ev[4]),
        .i_command_reset_received(ev[5]), .i_ack_or_timeout_event(ev[6]), .i_iso_tx_format_error(ev[7]),
        .i_async_first_entry_missed(ev[8]), .i_async_fifo_underflow(ev[9]),
        .i_general_receive_fifo_overflow(ev[10]), .i_packet_for_node(for_node), .i_header_crc_error(ev[11]),
        .i_transaction_code_error(ev[12]), .i_iso_cycle_start(ev[14]), .i_iso_cycle_end(ev[15]),
        .o_keep_self_ident_packets(keep_sid), .o_async_tx_enable(async_en), .o_iso_tx_enable(iso_en),
        .o_async_fifo_clear(fifo_clr), .o_rearbitrate(rearb), .o_busy_ack_send(busy),
        .o_discard_packet(discard), .o_interrupt(irq));
    wb_host_model wb_host_model_inst (.i_clock(i_clock), .i_wb_ack(o_wb_ack), .i_wb_dat(o_wb_dat),
        .o_wb_cyc(wb_cyc), .o_wb_stb(wb_stb), .o_wb_we(wb_we), .o_wb_adr(wb_adr), .o_wb_sel(wb_sel),
        .o_wb_dat(wb_dat));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %08Hh seen %08Hh", nm, exp, seen);
        end
    endtask
    task automatic chk1(input string nm, input logic seen, input logic exp);
        chk(nm, {31'h0, seen}, {31'h0, exp});
    endtask
    task automatic end_of_test();
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_host_model_inst.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb_host_model_inst.xfer(1'b0, a, 32'h0000_0000);
    endtask
    task automatic pulse(input int i);
        @(posedge i_clock);
        ev <= 16'h0001 << i;
        @(posedge i_clock);
        ev <= 16'h0000;
        #1;
    endtask
    // Read answers are matched against the oldest noted expectation
    always @(posedge i_clock) begin
        if (rearb === 1'b1) rearb_n++;
        if (o_wb_ack === 1'b1 && wb_we === 1'b0) begin
            if (exp_q.size() > 0) chk("read_data", o_wb_dat, exp_q.pop_front());
            else chk("read_count", 32'h0000_0001, 32'h0000_0000);
        end
    end
    initial begin
        void'($urandom(81170));
        repeat (6) @(posedge i_clock);
        i_rst_n <= 1'b1;
        #1;
        chk1("async_en", async_en, 1'b1);
        chk1("interrupt", irq, 1'b0);
        rd(ADDR_MASK, MASK_RESET);
        rd(ADDR_FLAGS, FLAGS_RESET);
        mval = $urandom() & (FLAG_IMPL_MASK | 32'h0000_0001);
        wr(ADDR_MASK, mval);
        rd(ADDR_MASK, mval);
        wr(ADDR_MASK, 32'h0000_0000);
        rd(8'hF0, 32'h0000_0000);
        wr(ADDR_CONTROL, 32'h0000_0002);
        #1;
        chk1("keep_sid", keep_sid, 1'b1);
        for (int i = 0; i < 13; i++) begin
            pulse(i);
            chk1("busy_ack", busy, 1'(i == 10));
            chk1("discard", discard, 1'(i == 11));
            rd(ADDR_FLAGS, 32'h1 << EB[i]);
            wr(ADDR_FLAGS, 32'h1 << EB[i]);
            rd(ADDR_FLAGS, 32'h0000_0000);
            repeat ($urandom_range(3)) @(posedge i_clock);
        end
        #1;
        chk1("async_en", async_en, 1'b0);
        chk1("iso_en", iso_en, 1'b1);
        wr(ADDR_FIFO_CTRL, 32'h0000_0001);
        #1;
        chk1("fifo_clr", fifo_clr, 1'b1);
        repeat (3) @(posedge i_clock);
        sid_recv <= 1'b1;
        #1;
        chk1("async_en", async_en, 1'b1);
        pulse(4);
        rd(ADDR_FLAGS, 32'h0000_0000);
        sid_recv <= 1'b0;
        pulse(2);
        rd(ADDR_FLAGS, 32'h0000_0050);
        wr(ADDR_FLAGS, 32'hFFFF_FFFF);
        wr(ADDR_MASK, 32'h0000_0101);
        pulse(6);
        rd(ADDR_FLAGS, 32'h0000_0101);
        #1;
        chk1("interrupt", irq, 1'b1);
        wr(ADDR_MASK, 32'h0000_0100);
        repeat (2) @(posedge i_clock);
        #1;
        chk1("interrupt", irq, 1'b0);
        rd(ADDR_FLAGS, 32'h0000_0101);
        wr(ADDR_MASK, 32'h0000_0000);
        wr(ADDR_DIAG, 32'h0000_0001);
        wr(ADDR_FLAGS, 32'hFFFF_FFFF);
        rd(ADDR_FLAGS, FLAG_IMPL_MASK);
        wr(ADDR_DIAG, 32'h0000_0000);
        wr(ADDR_FLAGS, 32'hFFFF_FFFF);
        rd(ADDR_FLAGS, 32'h0000_0000);
        for_node <= 1'b0;
        pulse(10);
        chk1("busy_ack", busy, 1'b0);
        rd(ADDR_FLAGS, 32'h0000_4000);
        wr(ADDR_FLAGS, 32'hFFFF_FFFF);
        for_node <= 1'b1;
        pulse(13);
        pulse(6);
        @(posedge i_clock);
        idle <= 1'b1;
        pulse(3);
        repeat (3) @(posedge i_clock);
        chk("rearb_count", 32'(rearb_n), 32'h0000_0001);
        acknowledge_valid <= 1'b1;
        pulse(13);
        pulse(6);
        pulse(3);
        repeat (3) @(posedge i_clock);
        chk("rearb_count", 32'(rearb_n), 32'h0000_0001);
        wr(ADDR_FLAGS, 32'hFFFF_FFFF);
        pulse(14);
        repeat (LIM + 5) @(posedge i_clock);
        rd(ADDR_FLAGS, 32'h0008_0000);
        wr(ADDR_FLAGS, 32'hFFFF_FFFF);
        pulse(15);
        pulse(14);
        repeat (LIM - 5) @(posedge i_clock);
        pulse(15);
        repeat (LIM) @(posedge i_clock);
        rd(ADDR_FLAGS, 32'h0000_0000);
        end_of_test();
    end
    initial begin
        repeat (4000) @(posedge i_clock);
        err_total++;
        end_of_test();
    end
endmodule
